// ### dtc_consts.svh
`ifndef DTC_CONSTS_SVH
`define DTC_CONSTS_SVH
// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define DTC_ADDR_CTRL 8'h88
`define DTC_ADDR_MODE 8'h89
`define DTC_ADDR_CH0_LOW 8'h8A
`define DTC_ADDR_CH1_LOW 8'h8B
`define DTC_ADDR_CH0_HIGH 8'h8C
`define DTC_ADDR_CH1_HIGH 8'h8D
`define DTC_ADDR_CLK 8'h8E
`define DTC_ADDR_PIN 8'hB5
`define DTC_ADDR_IRQ_STAT 8'hC0
`define DTC_ADDR_IRQ_MASK 8'hC1
// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define DTC_MODE_GATE0 3
`define DTC_MODE_FUNC0 2
`define DTC_MODE_GATE1 7
`define DTC_MODE_FUNC1 6
`define DTC_CTRL_RUN0 4
`define DTC_CTRL_FLAG0 5
`define DTC_CTRL_RUN1 6
`define DTC_CTRL_FLAG1 7
`define DTC_CLK_MODE0 3
`define DTC_CLK_MODE1 4
`define DTC_PIN_TOG0 2
`define DTC_PIN_TOG1 3
`define DTC_CTRL_WMASK 8'hF0
`define DTC_CLK_WMASK 8'h18
`define DTC_PIN_WMASK 8'h8D
`define DTC_IRQ_WMASK 8'h03
// ----------------------------------------------------------------
// reset values and timing
// ----------------------------------------------------------------
`define DTC_RST_BYTE 8'h00
`define DTC_PRESCALE 12
`endif

// ### dtc_pkg.sv
package dtc_pkg;
  typedef enum logic [1:0] {
    DTC_M13 = 2'b00,
    DTC_M16 = 2'b01,
    DTC_M8AR = 2'b10,
    DTC_MSPLIT = 2'b11
  } dtc_mode_e;
endpackage

// ### dtc_chan_if.sv
`timescale 1ns/1ps
`default_nettype none
interface dtc_chan_if;
  logic [7:0] low;
  logic [7:0] high;
  logic [1:0] mode;
  logic low_tick;
  logic high_tick;
  logic [7:0] low_nxt;
  logic [7:0] high_nxt;
  logic low_ovf;
  logic high_ovf;
  modport ctl (output low, high, mode, low_tick, high_tick, input low_nxt, high_nxt, low_ovf,
    high_ovf);
  modport cnt (input low, high, mode, low_tick, high_tick, output low_nxt, high_nxt, low_ovf,
    high_ovf);
endinterface
`default_nettype wire

// ### dtc_counter.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------------------------------
// next-count logic of one channel
// ----------------------------------------------------------------
module dtc_counter
  import dtc_pkg::*;
(
  dtc_chan_if.cnt ch
);
  logic [13:0] s13;
  logic [16:0] s16;
  logic [8:0] sl;
  logic [8:0] sh;
  always_comb begin
    s13 = {1'b0, ch.high, ch.low[4:0]} + 14'h0001;
    s16 = {1'b0, ch.high, ch.low} + 17'h00001;
    sl = {1'b0, ch.low} + 9'h001;
    sh = {1'b0, ch.high} + 9'h001;
    ch.low_nxt = ch.low;
    ch.high_nxt = ch.high;
    ch.low_ovf = 1'b0;
    ch.high_ovf = 1'b0;
    case (dtc_mode_e'(ch.mode))
      DTC_M13: begin
        if (ch.low_tick) begin
          ch.low_nxt = {ch.low[7:5], s13[4:0]}; // RULE16
          ch.high_nxt = s13[12:5];
          ch.low_ovf = s13[13];
        end
      end
      DTC_M16: begin
        if (ch.low_tick) begin
          ch.low_nxt = s16[7:0]; // RULE17
          ch.high_nxt = s16[15:8];
          ch.low_ovf = s16[16];
        end
      end
      DTC_M8AR: begin
        if (ch.low_tick) begin
          ch.low_nxt = sl[8] ? ch.high : sl[7:0]; // RULE18
          ch.low_ovf = sl[8];
        end
      end
      DTC_MSPLIT: begin
        if (ch.low_tick) begin
          ch.low_nxt = sl[7:0]; // RULE12
          ch.low_ovf = sl[8];
        end
        if (ch.high_tick) begin
          ch.high_nxt = sh[7:0];
          ch.high_ovf = sh[8];
        end
      end
      default: begin
        ch.low_nxt = ch.low;
      end
    endcase
  end
endmodule
`default_nettype wire

// ### dtc_top.sv
// Our own choice: strobed register access.
`timescale 1ns/1ps
`default_nettype none
`include "dtc_consts.svh"
// How it works
// (RULE1) each channel counts in a high byte and a low byte, both addressable
// (RULE2) function bit picks internal ticks or count-pin falling edges
// (RULE3) timer tick is clock divided by twelve, or clock itself
// (RULE4) pin sampled each clock; high then low counts once
// (RULE5) toggle enable inverts the count pin on every overflow
// (RULE6) pin drives high after toggle enable until first overflow
// (RULE7) software enables toggle only in timer function
// (RULE8) byte registers accessed independently, no coherence latch
// (RULE9) software should stop a channel before touching its bytes
// (RULE10) gate bit makes counting also need the interrupt pin high
// (RULE11) channel 1 modes: 13-bit, 16-bit, 8-bit reload, halt
// (RULE12) channel 0 mode 11 splits into two 8-bit counters
// (RULE13) mode register holds all fields read/write, resets to zero
// (RULE14) run bit clear halts and keeps count; set enables counting
// (RULE15) overflow sets flag; service ack clears; software may write it
// (RULE16) 13-bit mode uses high byte and five low bits
// (RULE17) 16-bit mode overflows from FFFF to 0000
// (RULE18) 8-bit mode reloads low byte from high byte on overflow
// (RULE19) split high byte uses channel 1 run bit and flag
module dtc_top
  import dtc_pkg::*;
(
  // clock and reset
  input wire logic mclk_i,
  input wire logic sys_rst_i,
  // register port
  input wire logic [7:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [7:0] rdata_o,
  // interrupt service acknowledges
  input wire logic ch0_irq_ack_i,
  input wire logic ch1_irq_ack_i,
  // pins
  input wire logic ext_irq0_pin_i,
  input wire logic ext_irq1_pin_i,
  input wire logic ch0_count_pin_i,
  input wire logic ch1_count_pin_i,
  output logic ch0_count_pin_o,
  output logic ch0_count_pin_oe_o,
  output logic ch1_count_pin_o,
  output logic ch1_count_pin_oe_o,
  // interrupt
  output logic irq_o
);
  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  logic [7:0] timer_mode_select_r, timer_mode_select_nxt;
  logic [7:0] timer_control_reg_r, timer_control_reg_nxt;
  logic [7:0] clock_control_reg_r, clock_control_reg_nxt;
  logic [7:0] pin_setting_r, pin_setting_nxt;
  logic [7:0] ch0_count_low_r, ch0_count_low_nxt;
  logic [7:0] ch0_count_high_r, ch0_count_high_nxt;
  logic [7:0] ch1_count_low_r, ch1_count_low_nxt;
  logic [7:0] ch1_count_high_r, ch1_count_high_nxt;
  logic [1:0] irq_stat_r, irq_stat_nxt;
  logic [1:0] irq_mask_r, irq_mask_nxt;
  logic [1:0] tog_r, tog_nxt;
  logic [7:0] rdata_r, rdata_nxt;
  logic [3:0] pre_r, pre_nxt;
  logic [2:0] p0_sync_r, p0_sync_nxt;
  logic [2:0] p1_sync_r, p1_sync_nxt;
  logic [2:0] g0_sync_r, g0_sync_nxt;
  logic [2:0] g1_sync_r, g1_sync_nxt;
  logic p0_lvl_r, p0_lvl_nxt;
  logic p1_lvl_r, p1_lvl_nxt;
  logic p0_prev_r, p0_prev_nxt;
  logic p1_prev_r, p1_prev_nxt;
  logic g0_lvl_r, g0_lvl_nxt;
  logic g1_lvl_r, g1_lvl_nxt;
  // ----------------------------------------------------------------
  // tick generation
  // ----------------------------------------------------------------
  logic pre_en, fall0, fall1, gate0, gate1;
  logic run0, run1, t0_tick, t1_tick, c0_tick, c0h_tick, c1_tick;
  assign pre_en = (pre_r == 4'(`DTC_PRESCALE - 1)); // RULE3
  assign fall0 = p0_prev_r & ~p0_lvl_r; // RULE4
  assign fall1 = p1_prev_r & ~p1_lvl_r;
  assign gate0 = ~timer_mode_select_r[`DTC_MODE_GATE0] | g0_lvl_r; // RULE10
  assign gate1 = ~timer_mode_select_r[`DTC_MODE_GATE1] | g1_lvl_r;
  assign run0 = timer_control_reg_r[`DTC_CTRL_RUN0] & gate0; // RULE14
  assign run1 = timer_control_reg_r[`DTC_CTRL_RUN1] & gate1;
  assign t0_tick = clock_control_reg_r[`DTC_CLK_MODE0] | pre_en; // RULE3
  assign t1_tick = clock_control_reg_r[`DTC_CLK_MODE1] | pre_en;
  assign c0_tick = run0 &
    (timer_mode_select_r[`DTC_MODE_FUNC0] ? fall0 : t0_tick); // RULE2
  assign c0h_tick = timer_control_reg_r[`DTC_CTRL_RUN1] & t0_tick; // RULE19
  assign c1_tick = run1 & (timer_mode_select_r[5:4] != DTC_MSPLIT) &
    (timer_mode_select_r[`DTC_MODE_FUNC1] ? fall1 : t1_tick); // RULE11
  // ----------------------------------------------------------------
  // channel counters
  // ----------------------------------------------------------------
  dtc_chan_if ch0 ();
  dtc_chan_if ch1 ();
  assign ch0.low = ch0_count_low_r;
  assign ch0.high = ch0_count_high_r;
  assign ch0.mode = timer_mode_select_r[1:0]; // RULE12
  assign ch0.low_tick = c0_tick;
  assign ch0.high_tick = c0h_tick;
  assign ch1.low = ch1_count_low_r;
  assign ch1.high = ch1_count_high_r;
  assign ch1.mode = timer_mode_select_r[5:4]; // RULE11
  assign ch1.low_tick = c1_tick;
  assign ch1.high_tick = 1'b0;
  dtc_counter u_cnt0 (.ch(ch0));
  dtc_counter u_cnt1 (.ch(ch1));
  logic split0, ovf0, ovf1;
  assign split0 = (timer_mode_select_r[1:0] == DTC_MSPLIT);
  assign ovf0 = ch0.low_ovf;
  assign ovf1 = ch1.low_ovf | (split0 & ch0.high_ovf); // RULE19
  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  logic [7:0] ctrl_w;
  always_comb begin
    pre_nxt = pre_en ? 4'h0 : pre_r + 4'h1;
    p0_sync_nxt = {p0_sync_r[1:0], ch0_count_pin_i};
    p1_sync_nxt = {p1_sync_r[1:0], ch1_count_pin_i};
    g0_sync_nxt = {g0_sync_r[1:0], ext_irq0_pin_i};
    g1_sync_nxt = {g1_sync_r[1:0], ext_irq1_pin_i};
    p0_lvl_nxt = (p0_sync_r[2] == p0_sync_r[1]) ? p0_sync_r[2] : p0_lvl_r;
    p1_lvl_nxt = (p1_sync_r[2] == p1_sync_r[1]) ? p1_sync_r[2] : p1_lvl_r;
    g0_lvl_nxt = (g0_sync_r[2] == g0_sync_r[1]) ? g0_sync_r[2] : g0_lvl_r;
    g1_lvl_nxt = (g1_sync_r[2] == g1_sync_r[1]) ? g1_sync_r[2] : g1_lvl_r;
    p0_prev_nxt = p0_lvl_r;
    p1_prev_nxt = p1_lvl_r;
    timer_mode_select_nxt = timer_mode_select_r;
    clock_control_reg_nxt = clock_control_reg_r;
    pin_setting_nxt = pin_setting_r;
    irq_mask_nxt = irq_mask_r;
    ch0_count_low_nxt = ch0.low_nxt; // RULE1
    ch0_count_high_nxt = ch0.high_nxt;
    ch1_count_low_nxt = ch1.low_nxt;
    ch1_count_high_nxt = ch1.high_nxt;
    ctrl_w = timer_control_reg_r;
    if (wr_i) begin
      case (addr_i)
        `DTC_ADDR_MODE: timer_mode_select_nxt = wdata_i; // RULE13
        `DTC_ADDR_CTRL: ctrl_w = (wdata_i & `DTC_CTRL_WMASK) |
          (timer_control_reg_r & ~`DTC_CTRL_WMASK);
        `DTC_ADDR_CLK: clock_control_reg_nxt = wdata_i & `DTC_CLK_WMASK;
        `DTC_ADDR_PIN: pin_setting_nxt = wdata_i & `DTC_PIN_WMASK;
        `DTC_ADDR_CH0_LOW: ch0_count_low_nxt = wdata_i; // RULE8
        `DTC_ADDR_CH0_HIGH: ch0_count_high_nxt = wdata_i;
        `DTC_ADDR_CH1_LOW: ch1_count_low_nxt = wdata_i;
        `DTC_ADDR_CH1_HIGH: ch1_count_high_nxt = wdata_i;
        `DTC_ADDR_IRQ_MASK: irq_mask_nxt = wdata_i[1:0] & 2'(`DTC_IRQ_WMASK);
        default: ctrl_w = timer_control_reg_r;
      endcase
    end
    timer_control_reg_nxt = ctrl_w;
    if (ch0_irq_ack_i) begin
      timer_control_reg_nxt[`DTC_CTRL_FLAG0] = 1'b0; // RULE15
    end
    if (ch1_irq_ack_i) begin
      timer_control_reg_nxt[`DTC_CTRL_FLAG1] = 1'b0;
    end
    if (ovf0) begin
      timer_control_reg_nxt[`DTC_CTRL_FLAG0] = 1'b1; // RULE15
    end
    if (ovf1) begin
      timer_control_reg_nxt[`DTC_CTRL_FLAG1] = 1'b1;
    end
    irq_stat_nxt = irq_stat_r;
    if (wr_i && addr_i == `DTC_ADDR_IRQ_STAT) begin
      irq_stat_nxt = irq_stat_r & ~wdata_i[1:0];
    end
    irq_stat_nxt = irq_stat_nxt | {ovf1, ovf0};
    tog_nxt = tog_r;
    if (!pin_setting_r[`DTC_PIN_TOG0]) begin
      tog_nxt[0] = 1'b1; // RULE6
    end else if (ovf0) begin
      tog_nxt[0] = ~tog_r[0]; // RULE5
    end
    if (!pin_setting_r[`DTC_PIN_TOG1]) begin
      tog_nxt[1] = 1'b1;
    end else if (ovf1) begin
      tog_nxt[1] = ~tog_r[1];
    end
    rdata_nxt = `DTC_RST_BYTE;
    if (rd_i) begin
      case (addr_i)
        `DTC_ADDR_MODE: rdata_nxt = timer_mode_select_r;
        `DTC_ADDR_CTRL: rdata_nxt = timer_control_reg_r;
        `DTC_ADDR_CLK: rdata_nxt = clock_control_reg_r;
        `DTC_ADDR_PIN: rdata_nxt = pin_setting_r;
        `DTC_ADDR_CH0_LOW: rdata_nxt = ch0_count_low_r; // RULE8
        `DTC_ADDR_CH0_HIGH: rdata_nxt = ch0_count_high_r;
        `DTC_ADDR_CH1_LOW: rdata_nxt = ch1_count_low_r;
        `DTC_ADDR_CH1_HIGH: rdata_nxt = ch1_count_high_r;
        `DTC_ADDR_IRQ_STAT: rdata_nxt = {6'h00, irq_stat_r};
        `DTC_ADDR_IRQ_MASK: rdata_nxt = {6'h00, irq_mask_r};
        default: rdata_nxt = `DTC_RST_BYTE;
      endcase
    end
  end
  // ----------------------------------------------------------------
  // state registers
  // ----------------------------------------------------------------
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      timer_mode_select_r <= `DTC_RST_BYTE; // RULE13
      timer_control_reg_r <= `DTC_RST_BYTE;
      clock_control_reg_r <= `DTC_RST_BYTE;
      pin_setting_r <= `DTC_RST_BYTE;
      ch0_count_low_r <= `DTC_RST_BYTE;
      ch0_count_high_r <= `DTC_RST_BYTE;
      ch1_count_low_r <= `DTC_RST_BYTE;
      ch1_count_high_r <= `DTC_RST_BYTE;
      irq_stat_r <= 2'h0;
      irq_mask_r <= 2'h0;
      tog_r <= 2'h3;
      rdata_r <= `DTC_RST_BYTE;
      pre_r <= 4'h0;
      p0_sync_r <= 3'h7;
      p1_sync_r <= 3'h7;
      g0_sync_r <= 3'h0;
      g1_sync_r <= 3'h0;
      p0_lvl_r <= 1'b1;
      p1_lvl_r <= 1'b1;
      g0_lvl_r <= 1'b0;
      g1_lvl_r <= 1'b0;
      p0_prev_r <= 1'b1;
      p1_prev_r <= 1'b1;
    end else begin
      timer_mode_select_r <= timer_mode_select_nxt;
      timer_control_reg_r <= timer_control_reg_nxt;
      clock_control_reg_r <= clock_control_reg_nxt;
      pin_setting_r <= pin_setting_nxt;
      ch0_count_low_r <= ch0_count_low_nxt;
      ch0_count_high_r <= ch0_count_high_nxt;
      ch1_count_low_r <= ch1_count_low_nxt;
      ch1_count_high_r <= ch1_count_high_nxt;
      irq_stat_r <= irq_stat_nxt;
      irq_mask_r <= irq_mask_nxt;
      tog_r <= tog_nxt;
      rdata_r <= rdata_nxt;
      pre_r <= pre_nxt;
      p0_sync_r <= p0_sync_nxt;
      p1_sync_r <= p1_sync_nxt;
      g0_sync_r <= g0_sync_nxt;
      g1_sync_r <= g1_sync_nxt;
      p0_lvl_r <= p0_lvl_nxt;
      p1_lvl_r <= p1_lvl_nxt;
      g0_lvl_r <= g0_lvl_nxt;
      g1_lvl_r <= g1_lvl_nxt;
      p0_prev_r <= p0_prev_nxt;
      p1_prev_r <= p1_prev_nxt;
    end
  end
  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign rdata_o = rdata_r;
  assign irq_o = |(irq_stat_r & irq_mask_r);
  assign ch0_count_pin_o = tog_r[0]; // RULE5
  assign ch1_count_pin_o = tog_r[1];
  assign ch0_count_pin_oe_o = pin_setting_r[`DTC_PIN_TOG0]; // RULE7
  assign ch1_count_pin_oe_o = pin_setting_r[`DTC_PIN_TOG1];
  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  sequence s_ovf0;
    ovf0;
  endsequence
  property p_flag0_set;
    @(posedge mclk_i) disable iff (sys_rst_i)
      s_ovf0 |=> timer_control_reg_r[`DTC_CTRL_FLAG0];
  endproperty
  a_flag0_set: assert property (p_flag0_set) else $error("flag0 not set"); // RULE15
  property p_halt_keeps;
    @(posedge mclk_i) disable iff (sys_rst_i)
      (!timer_control_reg_r[`DTC_CTRL_RUN0] && !wr_i) |=> $stable(ch0_count_low_r);
  endproperty
  a_halt_keeps: assert property (p_halt_keeps) else $error("halted count moved"); // RULE14
  property p_div12;
    @(posedge mclk_i) disable iff (sys_rst_i)
      pre_en |=> !pre_en [*8] ##1 !pre_en [*3] ##1 pre_en;
  endproperty
  a_div12: assert property (p_div12) else $error("prescale not twelve"); // RULE3
  property p_toggle;
    @(posedge mclk_i) disable iff (sys_rst_i)
      (ovf0 && pin_setting_r[`DTC_PIN_TOG0]) |=> ch0_count_pin_o != $past(ch0_count_pin_o);
  endproperty
  a_toggle: assert property (p_toggle) else $error("pin not toggled"); // RULE5
  property p_idle_high;
    @(posedge mclk_i) disable iff (sys_rst_i)
      !pin_setting_r[`DTC_PIN_TOG1] |=> ch1_count_pin_o;
  endproperty
  a_idle_high: assert property (p_idle_high) else $error("pin not high"); // RULE6
  property p_m16_wrap;
    @(posedge mclk_i) disable iff (sys_rst_i)
      (ch1.mode == 2'b01 && c1_tick && ch1_count_high_r == 8'hFF && ch1_count_low_r == 8'hFF
        && !wr_i) |=> (ch1_count_low_r == 8'h00 && timer_control_reg_r[`DTC_CTRL_FLAG1]);
  endproperty
  a_m16_wrap: assert property (p_m16_wrap) else $error("16-bit wrap wrong"); // RULE17
  property p_gate;
    @(posedge mclk_i) disable iff (sys_rst_i)
      (timer_mode_select_r[`DTC_MODE_GATE0] && !g0_lvl_r) |-> !c0_tick;
  endproperty
  a_gate: assert property (p_gate) else $error("gated channel counted"); // RULE10
  property p_halt1;
    @(posedge mclk_i) disable iff (sys_rst_i)
      (timer_mode_select_r[5:4] == 2'b11) |-> !c1_tick;
  endproperty
  a_halt1: assert property (p_halt1) else $error("channel 1 counts in halt"); // RULE11
  property p_reload;
    @(posedge mclk_i) disable iff (sys_rst_i)
      (ch0.mode == 2'b10 && c0_tick && ch0_count_low_r == 8'hFF && !wr_i) |=>
        ch0_count_low_r == $past(ch0_count_high_r);
  endproperty
  a_reload: assert property (p_reload) else $error("reload wrong"); // RULE18
  property p_edge;
    @(posedge mclk_i) disable iff (sys_rst_i)
      (timer_mode_select_r[`DTC_MODE_FUNC0] && run0) |-> (c0_tick == fall0);
  endproperty
  a_edge: assert property (p_edge) else $error("edge count wrong"); // RULE4
  property p_ovf_stat;
    @(posedge mclk_i) disable iff (sys_rst_i)
      s_ovf0 |=> irq_stat_r[0];
  endproperty
  a_ovf_stat: assert property (p_ovf_stat) else $error("status not set"); // RULE15
  property p_ack_clear;
    @(posedge mclk_i) disable iff (sys_rst_i)
      (ch0_irq_ack_i && !ovf0 && !(wr_i && addr_i == `DTC_ADDR_CTRL)) |=>
        !timer_control_reg_r[`DTC_CTRL_FLAG0];
  endproperty
  a_ack_clear: assert property (p_ack_clear) else $error("ack kept flag"); // RULE15
  property p_rdata_idle;
    @(posedge mclk_i) disable iff (sys_rst_i)
      !rd_i |=> rdata_o == `DTC_RST_BYTE;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data not idle"); // RULE8
  property p_byte_write;
    @(posedge mclk_i) disable iff (sys_rst_i)
      (wr_i && addr_i == `DTC_ADDR_CH0_HIGH) |=> ch0_count_high_r == $past(wdata_i);
  endproperty
  a_byte_write: assert property (p_byte_write) else $error("byte write lost"); // RULE8
  property p_mode_write;
    @(posedge mclk_i) disable iff (sys_rst_i)
      (wr_i && addr_i == `DTC_ADDR_MODE) |=> timer_mode_select_r == $past(wdata_i);
  endproperty
  a_mode_write: assert property (p_mode_write) else $error("mode write lost"); // RULE13
endmodule
`default_nettype wire

// ### dtc_pin_model.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------------------------------
// far-side pin model: count pulses and shared pin level
// ----------------------------------------------------------------
module dtc_pin_model (
  // clock
  input wire logic mclk_i,
  // pulse requests, one cycle each
  input wire logic [1:0] pulse_i,
  // design pin drive
  input wire logic [1:0] pin_o_i,
  input wire logic [1:0] pin_oe_i,
  // resolved pin level
  output logic [1:0] pin_wire_o
);
  logic [3:0] low_cnt_r [2];
  logic [1:0] level;
  initial begin
    low_cnt_r[0] = 4'h0;
    low_cnt_r[1] = 4'h0;
  end
  // each request holds the pin low for ten cycles
  always @(posedge mclk_i) begin
    for (int k = 0; k < 2; k++) begin
      if (pulse_i[k]) begin
        low_cnt_r[k] <= 4'hA;
      end else if (low_cnt_r[k] != 4'h0) begin
        low_cnt_r[k] <= low_cnt_r[k] - 4'h1;
      end
    end
  end
  // pull-up holds the pin high outside pulses; design drive wins when enabled
  always_comb begin
    for (int k = 0; k < 2; k++) begin
      level[k] = (low_cnt_r[k] == 4'h0);
      pin_wire_o[k] = pin_oe_i[k] ? pin_o_i[k] : level[k];
    end
  end
endmodule
`default_nettype wire

// ### dtc_top_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "dtc_consts.svh"
module dtc_top_tb_top;
  logic mclk_i, sys_rst_i, wr, rd, ack0, ack1, irq;
  logic [7:0] addr, wdata, rdata, d;
  logic [1:0] gate, pulse, pin_o, pin_oe, pin_wire;
  int errors, n_tests, cyc;
  dtc_top dut (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .addr_i(addr), .wdata_i(wdata),
    .wr_i(wr), .rd_i(rd), .rdata_o(rdata), .ch0_irq_ack_i(ack0), .ch1_irq_ack_i(ack1),
    .ext_irq0_pin_i(gate[0]), .ext_irq1_pin_i(gate[1]), .ch0_count_pin_i(pin_wire[0]),
    .ch1_count_pin_i(pin_wire[1]), .ch0_count_pin_o(pin_o[0]), .ch0_count_pin_oe_o(pin_oe[0]),
    .ch1_count_pin_o(pin_o[1]), .ch1_count_pin_oe_o(pin_oe[1]), .irq_o(irq));
  dtc_pin_model pins (.mclk_i(mclk_i), .pulse_i(pulse), .pin_o_i(pin_o), .pin_oe_i(pin_oe),
    .pin_wire_o(pin_wire));
  // ----------------------------------------------------------------
  // bus tasks and compares
  // ----------------------------------------------------------------
  task automatic w(input logic [7:0] a, input logic [7:0] v);
    @(posedge mclk_i);
    addr <= a;
    wdata <= v;
    wr <= 1'b1;
    @(posedge mclk_i);
    wr <= 1'b0;
  endtask
  task automatic r(input logic [7:0] a, output logic [7:0] v);
    @(posedge mclk_i);
    addr <= a;
    rd <= 1'b1;
    @(posedge mclk_i);
    rd <= 1'b0;
    #1 v = rdata;
  endtask
  task automatic cmp_byte(input string name, input logic [7:0] e, input logic [7:0] g);
    n_tests++;
    if (g !== e) begin
      errors++;
      $display("Error %s expected %h seen %h", name, e, g);
    end
  endtask
  task automatic cmp_bit(input string name, input logic e, input logic g);
    n_tests++;
    if (g !== e) begin
      errors++;
      $display("Error %s expected %b seen %b", name, e, g);
    end
  endtask
  task automatic chk(input string name, input logic [7:0] a, input logic [7:0] e);
    logic [7:0] v;
    r(a, v);
    cmp_byte(name, e, v);
  endtask
  task automatic set_count(input logic [7:0] ch, input logic [7:0] lo, input logic [7:0] hi);
    w(`DTC_ADDR_CH0_LOW + ch, lo);
    w(`DTC_ADDR_CH0_HIGH + ch, hi);
  endtask
  // run bits on for n clock edges, then stopped before any byte access
  task automatic run_ticks(input logic [7:0] on, input int n);
    w(`DTC_ADDR_CTRL, on);
    repeat (n - 2) @(posedge mclk_i);
    w(`DTC_ADDR_CTRL, 8'h00);
  endtask
  task automatic ack(input int ch);
    @(posedge mclk_i);
    if (ch == 1) ack1 <= 1'b1;
    else ack0 <= 1'b1;
    @(posedge mclk_i);
    ack0 <= 1'b0;
    ack1 <= 1'b0;
  endtask
  task automatic settle();
    @(posedge mclk_i);
    #1;
  endtask
  task automatic summarize();
    $display("checks %0d errors %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // ----------------------------------------------------------------
  // clock, timeout and tests
  // ----------------------------------------------------------------
  initial mclk_i = 1'b0;
  always #25 mclk_i = ~mclk_i;
  always @(posedge mclk_i) begin
    cyc <= cyc + 1;
    if (cyc == 8000) begin
      errors++;
      summarize();
    end
  end
  initial begin
    sys_rst_i = 1'b1;
    {wr, rd, ack0, ack1} = 4'h0;
    {addr, wdata} = 16'h0000;
    gate = 2'b00;
    pulse = 2'b00;
    {errors, n_tests, cyc} = 0;
    repeat (2) @(posedge mclk_i);
    sys_rst_i <= 1'b0;
    settle();
    cmp_bit("pin0 out", 1'b1, pin_o[0]);
    cmp_bit("pin0 oe", 1'b0, pin_oe[0]);
    for (int i = 0; i < 7; i++) chk("reset", `DTC_ADDR_CTRL + i[7:0], 8'h00);
    chk("pin reg", `DTC_ADDR_PIN, 8'h00);
    chk("irq stat", `DTC_ADDR_IRQ_STAT, 8'h00);
    w(8'h90, 8'hFF);
    chk("unmapped", 8'h90, 8'h00);
    w(`DTC_ADDR_MODE, 8'hA5);
    chk("mode", `DTC_ADDR_MODE, 8'hA5);
    w(`DTC_ADDR_MODE, 8'h5A);
    chk("mode", `DTC_ADDR_MODE, 8'h5A);
    for (int i = 0; i < 4; i++) w(`DTC_ADDR_CH0_LOW + i[7:0], 8'h11 * (i[7:0] + 8'h01));
    for (int i = 0; i < 4; i++) chk("byte", `DTC_ADDR_CH0_LOW + i[7:0], 8'h11 * (i[7:0] + 8'h01));
    $display("test registers done");
    for (int ch = 0; ch < 2; ch++) begin
      w(`DTC_ADDR_MODE, ch ? 8'h50 : 8'h05);
      set_count(ch[7:0], 8'h00, 8'h00);
      w(`DTC_ADDR_CTRL, ch ? 8'h40 : 8'h10);
      repeat (3) begin
        @(posedge mclk_i);
        pulse[ch] <= 1'b1;
        @(posedge mclk_i);
        pulse[ch] <= 1'b0;
        repeat (20) @(posedge mclk_i);
      end
      w(`DTC_ADDR_CTRL, 8'h00);
      chk("edges", `DTC_ADDR_CH0_LOW + ch[7:0], 8'h03);
      repeat (10) @(posedge mclk_i);
      chk("held", `DTC_ADDR_CH0_LOW + ch[7:0], 8'h03);
    end
    $display("test counter done");
    w(`DTC_ADDR_CLK, 8'h08);
    w(`DTC_ADDR_MODE, 8'h01);
    set_count(0, 8'h00, 8'h00);
    run_ticks(8'h10, 40);
    chk("fast ticks", `DTC_ADDR_CH0_LOW, 8'h28);
    w(`DTC_ADDR_CLK, 8'h00);
    set_count(0, 8'h00, 8'h00);
    run_ticks(8'h10, 120);
    chk("slow ticks", `DTC_ADDR_CH0_LOW, 8'h0A);
    w(`DTC_ADDR_CLK, 8'h08);
    w(`DTC_ADDR_MODE, 8'h09);
    set_count(0, 8'h00, 8'h00);
    run_ticks(8'h10, 20);
    chk("gate low", `DTC_ADDR_CH0_LOW, 8'h00);
    @(posedge mclk_i);
    gate[0] <= 1'b1;
    repeat (6) @(posedge mclk_i);
    run_ticks(8'h10, 20);
    chk("gate high", `DTC_ADDR_CH0_LOW, 8'h14);
    $display("test timer done");
    w(`DTC_ADDR_MODE, 8'h00);
    set_count(0, 8'h1E, 8'h00);
    run_ticks(8'h10, 2);
    chk("13 carry", `DTC_ADDR_CH0_HIGH, 8'h01);
    set_count(0, 8'h1E, 8'hFF);
    run_ticks(8'h10, 2);
    chk("13 wrap", `DTC_ADDR_CH0_HIGH, 8'h00);
    chk("flag0", `DTC_ADDR_CTRL, 8'h20);
    chk("irq stat", `DTC_ADDR_IRQ_STAT, 8'h01);
    cmp_bit("irq masked", 1'b0, irq);
    w(`DTC_ADDR_IRQ_MASK, 8'h01);
    settle();
    cmp_bit("irq on", 1'b1, irq);
    w(`DTC_ADDR_IRQ_STAT, 8'h01);
    settle();
    cmp_bit("irq off", 1'b0, irq);
    ack(0);
    chk("ack0", `DTC_ADDR_CTRL, 8'h00);
    w(`DTC_ADDR_MODE, 8'h10);
    w(`DTC_ADDR_CLK, 8'h10);
    set_count(1, 8'hFE, 8'hFF);
    run_ticks(8'h40, 2);
    chk("16 wrap", `DTC_ADDR_CH1_HIGH, 8'h00);
    chk("flag1", `DTC_ADDR_CTRL, 8'h80);
    chk("irq stat", `DTC_ADDR_IRQ_STAT, 8'h02);
    cmp_bit("irq mask1", 1'b0, irq);
    ack(1);
    chk("ack1", `DTC_ADDR_CTRL, 8'h00);
    w(`DTC_ADDR_IRQ_STAT, 8'h02);
    w(`DTC_ADDR_CTRL, 8'h80);
    chk("sw flag", `DTC_ADDR_CTRL, 8'h80);
    $display("test overflow done");
    w(`DTC_ADDR_MODE, 8'h02);
    w(`DTC_ADDR_CLK, 8'h08);
    set_count(0, 8'hFE, 8'h40);
    run_ticks(8'h10, 2);
    chk("reload", `DTC_ADDR_CH0_LOW, 8'h40);
    chk("reload flag", `DTC_ADDR_CTRL, 8'h20);
    w(`DTC_ADDR_MODE, 8'h30);
    set_count(1, 8'h00, 8'h00);
    run_ticks(8'h40, 10);
    chk("halt1", `DTC_ADDR_CH1_LOW, 8'h00);
    w(`DTC_ADDR_MODE, 8'h03);
    set_count(0, 8'hFE, 8'hFE);
    run_ticks(8'h50, 2);
    chk("split lo", `DTC_ADDR_CH0_LOW, 8'h00);
    chk("split hi", `DTC_ADDR_CH0_HIGH, 8'h00);
    chk("split flags", `DTC_ADDR_CTRL, 8'hA0);
    w(`DTC_ADDR_IRQ_STAT, 8'h03);
    $display("test modes done");
    w(`DTC_ADDR_MODE, 8'h01);
    set_count(0, 8'hFE, 8'hFF);
    w(`DTC_ADDR_PIN, 8'h04);
    settle();
    cmp_bit("oe0", 1'b1, pin_oe[0]);
    cmp_bit("pin0 first", 1'b1, pin_wire[0]);
    run_ticks(8'h10, 2);
    settle();
    cmp_bit("pin0 toggled", 1'b0, pin_wire[0]);
    set_count(0, 8'hFE, 8'hFF);
    run_ticks(8'h10, 2);
    settle();
    cmp_bit("pin0 back", 1'b1, pin_wire[0]);
    w(`DTC_ADDR_PIN, 8'hFF);
    chk("pin reg", `DTC_ADDR_PIN, 8'h8D);
    settle();
    cmp_bit("oe1", 1'b1, pin_oe[1]);
    cmp_bit("pin1 first", 1'b1, pin_o[1]);
    $display("test toggle done");
    summarize();
  end
endmodule
`default_nettype wire
